// >>> spu_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module spu_ctl_model
   import spu_pkg::*;
(
   input  wire logic       core_clk,
   output logic            cke,
   output logic            cs_n,
   output logic            ca_hiz,
   output logic      [2:0] cmd_code,
   output logic      [7:0] mr_addr,
   output logic      [7:0] mr_wdata
);
   // Every wait in whole cycles, rounded up so it is never short
   localparam int CKE_LOW_CYC = 8;
   localparam int IDLE_CYC    = 5000;
   localparam int POST_CYC    = 25;

   initial begin
      cke = 1'b0;
      cs_n = 1'b1;
      ca_hiz = 1'b1;
      cmd_code = 3'h0;
      mr_addr = 8'h00;
      mr_wdata = 8'h00;
   end

   task automatic issue(input spu_cmd_t c, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      cs_n <= 1'b0;
      ca_hiz <= 1'b0;
      cmd_code <= c;
      mr_addr <= a;
      mr_wdata <= d;
   endtask

   // Floating bus: lines wander, device must see NOP
   task automatic idle(input int n);
      @(posedge core_clk);
      ca_hiz <= 1'b1;
      cmd_code <= ~cmd_code;
      mr_addr <= ~mr_addr;
      repeat (n) begin
         @(posedge core_clk);
         cmd_code <= cmd_code ^ 3'h7;
      end
   endtask

   // Command on the bus with select high: the device must ignore it
   task automatic issue_desel(input spu_cmd_t c);
      @(posedge core_clk);
      cs_n <= 1'b1;
      ca_hiz <= 1'b0;
      cmd_code <= c;
   endtask

   // Minimum NOP wait after a reset or calibration write
   task automatic settle();
      idle(POST_CYC);
   endtask

   task automatic power_up();
      cke <= 1'b0;
      repeat (CKE_LOW_CYC) @(posedge core_clk);
      cke <= 1'b1;
      idle(IDLE_CYC);
   endtask
endmodule // spu_ctl_model
`default_nettype wire

// >>> spu_init_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "spu_map.svh"
module spu_init_seq
   import spu_pkg::*;
#(
   parameter int AUTO_INIT_CYC = `SPU_AUTO_INIT_CYC,
   parameter int MR_DEPTH      = `SPU_MR_DEPTH
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       cke,
   input  wire logic       cs_n,
   input  wire logic       ca_hiz,
   input  wire logic [2:0] cmd_code,
   input  wire logic [7:0] mr_addr,
   input  wire logic [7:0] mr_wdata,
   output logic      [7:0] dq_out,
   output logic            dq_oe,
   output logic            auto_init_bit,
   output logic            init_done,
   output logic            cmd_reject,
   output logic      [2:0] seq_state
);
   localparam int CNT_W = `SPU_CNT_W;

   if (AUTO_INIT_CYC < 1 || AUTO_INIT_CYC >= (1 << CNT_W)) begin : g_bad_cyc
      $error("spu_init_seq: AUTO_INIT_CYC out of counter range");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode

   function automatic logic mrw_hit(input logic wr_ok, input logic [7:0] a, input logic [7:0] want);
      mrw_hit = wr_ok && (a == want);
   endfunction

   spu_cmd_t   cmd;
   logic       cmd_take;
   logic       allowed;
   logic       wr_ok;
   logic       rd_go;
   logic       is_reset;
   spu_state_t state_reg;
   spu_state_t state_next;

   always_comb begin
      cmd      = spu_cmd_t'(cmd_code);
      // Sampled on the rising edge; a floating bus or low enable is a NOP
      cmd_take = cke && !cs_n && !ca_hiz && (cmd != SPU_CMD_NOP);
      case (state_reg)
         SPU_ST_BOOT: begin
            allowed = (cmd == SPU_CMD_MRW) || (cmd == SPU_CMD_MRR) || (cmd == SPU_CMD_PREA);
         end
         SPU_ST_READY: begin
            allowed = 1'b1;
         end
         default: begin
            allowed = (cmd == SPU_CMD_MRW) || (cmd == SPU_CMD_MRR);
         end
      endcase
      wr_ok    = cmd_take && allowed && (cmd == SPU_CMD_MRW);
      rd_go    = cmd_take && allowed && (cmd == SPU_CMD_MRR);
      is_reset = mrw_hit(wr_ok, mr_addr, `SPU_MA_RESET);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequence state

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             dai_reg;
   logic             dai_next;
   logic [2:0]       cfg_reg;
   logic [2:0]       cfg_next;
   logic             rej_reg;
   logic             rej_next;
   logic             done_reg;
   logic             done_next;

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      dai_next   = dai_reg;
      cfg_next   = cfg_reg;
      rej_next   = cmd_take && !allowed;
      if (is_reset) begin
         // Restart from the reset step without any power ramp
         state_next = SPU_ST_AUTO_INIT;
         cnt_next   = '0;
         dai_next   = `SPU_DAI_RESET;
         cfg_next   = 3'h0;
      end else begin
         case (state_reg)
            SPU_ST_AUTO_INIT: begin
               if (cnt_reg == CNT_W'(AUTO_INIT_CYC - 1)) begin
                  state_next = SPU_ST_CAL;
                  dai_next   = 1'b0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            SPU_ST_CAL: begin
               if (mrw_hit(wr_ok, mr_addr, `SPU_MA_IO_CAL)) begin
                  state_next = SPU_ST_CONFIG;
               end
            end
            SPU_ST_CONFIG: begin
               cfg_next[0] = cfg_reg[0] | mrw_hit(wr_ok, mr_addr, `SPU_MA_FEATURE_ONE);
               cfg_next[1] = cfg_reg[1] | mrw_hit(wr_ok, mr_addr, `SPU_MA_FEATURE_TWO);
               cfg_next[2] = cfg_reg[2] | mrw_hit(wr_ok, mr_addr, `SPU_MA_IO_CONFIG);
               if (cfg_next == `SPU_CFG_ALL) begin
                  state_next = SPU_ST_READY;
               end
            end
            default: begin
               state_next = state_reg;
            end
         endcase
      end
      done_next = (state_next == SPU_ST_READY);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SPU_ST_BOOT;
         cnt_reg   <= '0;
         dai_reg   <= `SPU_DAI_RESET;
         cfg_reg   <= 3'h0;
         rej_reg   <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         dai_reg   <= dai_next;
         cfg_reg   <= cfg_next;
         rej_reg   <= rej_next;
         done_reg  <= done_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode register store and read path

   spu_mr_if mr_bus ();

   // The info register is read-only and reset is a trigger, so neither is stored
   assign mr_bus.wr_en   = wr_ok && (mr_addr != `SPU_MA_DEVICE_INFO) && !is_reset;
   assign mr_bus.wr_addr = mr_addr;
   assign mr_bus.wr_data = mr_wdata;
   assign mr_bus.rd_en   = rd_go;
   assign mr_bus.rd_addr = mr_addr;

   spu_mr_store #(
      .DEPTH (MR_DEPTH)
   ) u_store (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .mr       (mr_bus.mem)
   );

   logic       pend_reg;
   logic       pend_next;
   logic       info_reg;
   logic       info_next;
   logic       dai_snap_reg;
   logic       dai_snap_next;
   logic [7:0] dq_reg;
   logic [7:0] dq_next;
   logic       oe_reg;
   logic       oe_next;

   always_comb begin
      pend_next     = rd_go;
      info_next     = rd_go && (mr_addr == `SPU_MA_DEVICE_INFO);
      dai_snap_next = dai_reg;
      dq_next       = 8'h00;
      if (pend_reg) begin
         if (info_reg) begin
            dq_next[`SPU_DAI_BIT] = dai_snap_reg;
         end else begin
            dq_next = mr_bus.rd_data;
         end
      end
      // Drivers only turn on while the enable is sampled high
      oe_next = pend_reg && cke;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg     <= 1'b0;
         info_reg     <= 1'b0;
         dai_snap_reg <= `SPU_DAI_RESET;
         dq_reg       <= 8'h00;
         oe_reg       <= 1'b0;
      end else begin
         pend_reg     <= pend_next;
         info_reg     <= info_next;
         dai_snap_reg <= dai_snap_next;
         dq_reg       <= dq_next;
         oe_reg       <= oe_next;
      end
   end

   assign dq_out        = dq_reg;
   assign dq_oe         = oe_reg;
   assign auto_init_bit = dai_reg;
   assign init_done     = done_reg;
   assign cmd_reject    = rej_reg;
   assign seq_state     = state_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence reset_take_s;
      is_reset;
   endsequence

   sequence read_take_s;
      rd_go ##1 cke;
   endsequence

   hiz_cke_low_a: assert property (!cke |=> !dq_oe)
      else $error("data driven after low clock-enable");

   reset_restart_a: assert property (reset_take_s |=> seq_state == SPU_ST_AUTO_INIT && auto_init_bit && !init_done)
      else $error("reset command did not restart the sequence");

   dai_bound_a: assert property (auto_init_bit && seq_state == SPU_ST_AUTO_INIT && cnt_reg == CNT_W'(AUTO_INIT_CYC - 1) && !is_reset
                                 |=> !auto_init_bit && seq_state == SPU_ST_CAL)
      else $error("auto-init bit not cleared on time");

   dai_hold_a: assert property (seq_state == SPU_ST_AUTO_INIT |-> auto_init_bit)
      else $error("auto-init bit low during auto-init");

   read_data_a: assert property (read_take_s |=> dq_oe)
      else $error("register read gave no data");

   info_read_a: assert property (rd_go && mr_addr == `SPU_MA_DEVICE_INFO ##1 cke
                                 |=> dq_out[`SPU_DAI_BIT] == $past(auto_init_bit, 2))
      else $error("info register read wrong status");

   early_reject_a: assert property (cmd_take && cmd == SPU_CMD_ARRAY && seq_state != SPU_ST_READY && !is_reset
                                    |=> cmd_reject)
      else $error("array command accepted before init end");

   ready_accept_a: assert property (seq_state == SPU_ST_READY && cmd_take |=> !cmd_reject)
      else $error("command refused after init");

   ready_order_a: assert property ($rose(init_done) |-> $past(seq_state) == SPU_ST_CONFIG)
      else $error("init done without configuration");

   float_nop_a: assert property (ca_hiz |=> !cmd_reject ##1 !dq_oe)
      else $error("floating bus treated as command");

endmodule // spu_init_seq
`default_nettype wire

// >>> spu_init_seq_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module spu_init_seq_tb_top
   import spu_pkg::*;
;
   typedef struct {spu_cmd_t c; logic [7:0] a; logic [7:0] d; logic [7:0] e;} spu_row_t;
   logic       core_clk;
   logic       rst_n;
   wire        cke;
   wire        cs_n;
   wire        ca_hiz;
   wire  [2:0] cmd_code;
   wire  [7:0] mr_addr;
   wire  [7:0] mr_wdata;
   logic [7:0] dq_out;
   logic       dq_oe;
   logic       auto_init_bit;
   logic       init_done;
   logic       cmd_reject;
   logic [2:0] seq_state;
   int         mismatches = 0;
   int         n_tests = 0;
   spu_row_t   rows [7];

   spu_ctl_model spu_ctl_model_i (.core_clk(core_clk), .cke(cke), .cs_n(cs_n), .ca_hiz(ca_hiz),
      .cmd_code(cmd_code), .mr_addr(mr_addr), .mr_wdata(mr_wdata));
   spu_init_seq #(.AUTO_INIT_CYC(40)) spu_init_seq_i (.core_clk(core_clk), .rst_n(rst_n), .cke(cke),
      .cs_n(cs_n), .ca_hiz(ca_hiz), .cmd_code(cmd_code), .mr_addr(mr_addr), .mr_wdata(mr_wdata),
      .dq_out(dq_out), .dq_oe(dq_oe), .auto_init_bit(auto_init_bit), .init_done(init_done),
      .cmd_reject(cmd_reject), .seq_state(seq_state));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Non-read commands: reject stands for the cycle after the take edge
   task automatic cmd(input spu_cmd_t c, input logic [7:0] a, input logic [7:0] d, input logic r);
      spu_ctl_model_i.issue(c, a, d);
      spu_ctl_model_i.idle(0);
      #1 chk("cmd_reject", {7'h0, r}, {7'h0, cmd_reject});
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      spu_ctl_model_i.issue(SPU_CMD_MRR, a, 8'h00);
      spu_ctl_model_i.idle(1);
      #1 chk("dq_oe", 8'h01, {7'h0, dq_oe});
      v = dq_out;
   endtask

   task automatic st(input spu_state_t s, input logic d);
      chk("seq_state", {5'h0, s}, {5'h0, seq_state});
      chk("init_done", {7'h0, d}, {7'h0, init_done});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      final_report();
   end

   initial begin
      logic [7:0] v;
      rst_n = 1'b0;
      rows = '{'{SPU_CMD_MRW, 8'h01, 8'h5A, 8'h00}, '{SPU_CMD_MRR, 8'h01, 8'h00, 8'h5A},
               '{SPU_CMD_MRR, 8'h00, 8'h00, 8'h01}, '{SPU_CMD_MRR, 8'h20, 8'h00, 8'h00},
               '{SPU_CMD_PREA, 8'h00, 8'h00, 8'h00}, '{SPU_CMD_ARRAY, 8'h00, 8'h00, 8'h01},
               '{SPU_CMD_MRW, 8'h00, 8'hFF, 8'h00}};
      repeat (12) @(posedge core_clk);
      #1 st(SPU_ST_BOOT, 1'b0);
      chk("auto_init_bit", 8'h01, {7'h0, auto_init_bit});
      rst_n <= 1'b1;
      spu_ctl_model_i.power_up();
      #1 chk("dq_oe", 8'h00, {7'h0, dq_oe});
      chk("cmd_reject", 8'h00, {7'h0, cmd_reject});
      $display("reset and power-up done");
      foreach (rows[i]) begin
         if (rows[i].c == SPU_CMD_MRR) begin
            rd(rows[i].a, v);
            chk("dq_out", rows[i].e, v);
         end else cmd(rows[i].c, rows[i].a, rows[i].d, rows[i].e[0]);
      end
      rd(8'h00, v);
      chk("dq_out", 8'h01, v);
      spu_ctl_model_i.issue_desel(SPU_CMD_ARRAY);
      spu_ctl_model_i.idle(0);
      #1 chk("cmd_reject", 8'h00, {7'h0, cmd_reject});
      $display("boot table done");
      cmd(SPU_CMD_MRW, 8'h3F, 8'h00, 1'b0);
      st(SPU_ST_AUTO_INIT, 1'b0);
      spu_ctl_model_i.settle();
      cmd(SPU_CMD_PREA, 8'h00, 8'h00, 1'b1);
      v = 8'h01;
      for (int k = 0; k < 20 && v[0]; k++) rd(8'h00, v);
      chk("dq_out", 8'h00, v);
      st(SPU_ST_CAL, 1'b0);
      $display("auto init done");
      cmd(SPU_CMD_MRW, 8'h0A, 8'hFF, 1'b0);
      st(SPU_ST_CONFIG, 1'b0);
      spu_ctl_model_i.settle();
      spu_ctl_model_i.issue(SPU_CMD_MRW, 8'h03, 8'h02);
      spu_ctl_model_i.issue(SPU_CMD_MRW, 8'h01, 8'h03);
      #1 st(SPU_ST_CONFIG, 1'b0);
      spu_ctl_model_i.issue(SPU_CMD_MRW, 8'h02, 8'h04);
      spu_ctl_model_i.idle(1);
      #1 st(SPU_ST_READY, 1'b1);
      cmd(SPU_CMD_ARRAY, 8'h00, 8'h00, 1'b0);
      cmd(SPU_CMD_PREA, 8'h00, 8'h00, 1'b0);
      $display("configuration done");
      spu_ctl_model_i.issue(SPU_CMD_MRR, 8'h02, 8'h00);
      spu_ctl_model_i.idle(0);
      force_low();
      $display("clock-enable low read done");
      cmd(SPU_CMD_MRW, 8'h3F, 8'h00, 1'b0);
      st(SPU_ST_AUTO_INIT, 1'b0);
      chk("auto_init_bit", 8'h01, {7'h0, auto_init_bit});
      spu_ctl_model_i.settle();
      rd(8'h02, v);
      chk("dq_out", 8'h04, v);
      $display("second reset done");
      final_report();
   end

   // Read taken, then clock-enable dropped: nothing may be driven
   task automatic force_low();
      spu_ctl_model_i.cke <= 1'b0;
      @(posedge core_clk);
      #1 chk("dq_oe", 8'h00, {7'h0, dq_oe});
      @(posedge core_clk);
      spu_ctl_model_i.cke <= 1'b1;
   endtask
endmodule // spu_init_seq_tb_top
`default_nettype wire

// >>> spu_map.svh
`ifndef SPU_MAP_SVH
`define SPU_MAP_SVH

`define SPU_CLK_PERIOD_NS     40
`define SPU_AUTO_INIT_MAX_NS  10000
`define SPU_AUTO_INIT_CYC     (`SPU_AUTO_INIT_MAX_NS / `SPU_CLK_PERIOD_NS)
`define SPU_CNT_W             12
`define SPU_MR_DEPTH          16

`define SPU_MA_DEVICE_INFO    8'h00
`define SPU_MA_FEATURE_ONE    8'h01
`define SPU_MA_FEATURE_TWO    8'h02
`define SPU_MA_IO_CONFIG      8'h03
`define SPU_MA_IO_CAL         8'h0A
`define SPU_MA_RESET          8'h3F

`define SPU_DAI_BIT           0
`define SPU_DAI_RESET         1'b1
`define SPU_CFG_ALL           3'h7

`endif

// >>> spu_mr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spu_mr_if;
   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic       rd_en;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;

   modport ctl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface // spu_mr_if
`default_nettype wire

// >>> spu_mr_store.sv
`timescale 1ns/10ps
`default_nettype none
`include "spu_map.svh"
module spu_mr_store
   import spu_pkg::*;
#(
   parameter int DEPTH = `SPU_MR_DEPTH
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   spu_mr_if.mem     mr
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || DEPTH > 256 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("spu_mr_store: DEPTH must be a power of two from 2 to 256");
   end

   logic [7:0] ents [DEPTH];
   logic [7:0] rd_reg;
   logic [7:0] rd_next;

   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      logic [7:0] ent_reg;
      logic [7:0] ent_next;
      always_comb begin
         ent_next = ent_reg;
         if (mr.wr_en && mr.wr_addr == 8'(i)) begin
            ent_next = mr.wr_data;
         end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            ent_reg <= 8'h00;
         end else begin
            ent_reg <= ent_next;
         end
      end
      assign ents[i] = ent_reg;
   end

   // Addresses past the store read as zero, like unused fields
   always_comb begin
      rd_next = rd_reg;
      if (mr.rd_en) begin
         rd_next = (32'(mr.rd_addr) < DEPTH) ? ents[mr.rd_addr[AW-1:0]] : 8'h00;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_reg <= 8'h00;
      end else begin
         rd_reg <= rd_next;
      end
   end

   assign mr.rd_data = rd_reg;
endmodule // spu_mr_store
`default_nettype wire

// >>> spu_pkg.sv
`default_nettype none
package spu_pkg;

   typedef enum logic [2:0] {
      SPU_CMD_NOP  = 3'h0,
      SPU_CMD_MRW  = 3'h1,
      SPU_CMD_MRR  = 3'h2,
      SPU_CMD_PREA = 3'h3,
      SPU_CMD_ARRAY = 3'h4
   } spu_cmd_t;

   typedef enum logic [2:0] {
      SPU_ST_BOOT      = 3'h0,
      SPU_ST_AUTO_INIT = 3'h1,
      SPU_ST_CAL       = 3'h2,
      SPU_ST_CONFIG    = 3'h3,
      SPU_ST_READY     = 3'h4
   } spu_state_t;

endpackage
`default_nettype wire
